// ===== verilog/acv_pkg.sv
// acv_pkg: shared constants and types for the converter control block
// assumes a single 125 MHz clock shared by both ends
`default_nettype none
package acv_pkg;
    localparam int ACV_DATA_W = 8;
    localparam int ACV_ADDR_W = 16;
    localparam int ACV_CLK_NS = 8;
    // approximation cycles per conversion, one per result bit plus one settle
    localparam int ACV_CONV_STEPS = 9;
    // conversion clock divider relative to the system clock
    localparam int ACV_CCLK_DIV = 4;
    localparam logic [ACV_DATA_W-1:0] ACV_CODE_ZERO = 8'h00;
    localparam logic [ACV_DATA_W-1:0] ACV_CODE_FULL = 8'hff;
    // analog span divided into this many code steps
    localparam int ACV_SPAN_STEPS = 256;
    // decoder matches the top hex digit of the address
    localparam logic [3:0] ACV_DEC_NIBBLE = 4'h5;
    localparam logic [ACV_ADDR_W-1:0] ACV_CONV_ADDR = 16'h5000;
    localparam logic [ACV_ADDR_W-1:0] ACV_STORE_FIRST = 16'h0200;
    localparam logic [ACV_ADDR_W-1:0] ACV_STORE_LAST = 16'h020f;
    // sets the power-up initialising pulse, which lasts this many clocks minus one
    localparam int ACV_INIT_PULSE = 2;
    typedef enum logic [1:0] {
        ACV_IDLE = 2'b00,
        ACV_CONV = 2'b01,
        ACV_DONE = 2'b10
    } acv_state_e;
    typedef enum logic [2:0] {
        ACV_H_START = 3'b000,
        ACV_H_STROBE = 3'b001,
        ACV_H_WAIT = 3'b010,
        ACV_H_READ = 3'b011,
        ACV_H_RELEASE = 3'b100,
        ACV_H_INIT = 3'b101,
        ACV_H_FREE = 3'b110
    } acv_host_e;
endpackage
`default_nettype wire

// ===== verilog/acv_if.sv
// acv_if: bus between converter channels and the host
// assumes both ends on the same clock; the bench resolves the data bus
`default_nettype none
interface acv_if #(parameter int NCH = 1) (input wire logic clock);
    import acv_pkg::*;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic [ACV_ADDR_W-1:0] addr;
    logic [NCH-1:0] conversion_done_n;
    logic [NCH*ACV_DATA_W-1:0] dev_data;
    logic [NCH-1:0] dev_data_oe;
    modport device (input cs_n, wr_n, rd_n, output conversion_done_n, dev_data, dev_data_oe);
    modport host (output cs_n, wr_n, rd_n, addr,
        input conversion_done_n, dev_data, dev_data_oe);
endinterface
`default_nettype wire

// ===== verilog/acv_conv.sv
// acv_conv: NCH converter channels sharing one chip select and strobes
// assumes strobes synchronous to clock; analog input is a sampled code per channel
// Notes on behaviour
// (R1) restart while converting aborts, starts afresh
// (R2) aborted conversion never loads result latch
// (R3) done stays high on a restart
// (R4) free-run: cs low, write tied done
// (R5) host pulses joined node low after power-up
// (R6) eight-bit code, step is span/256
// (R7) top transition 1.5 steps below full
// (R8) conversion clock from host or own divider
// (R9) fast host stretches its bus cycles
// (R10) one write starts every channel together
// (R11) host loop stores to 0200..020f, wraps
// (R12) host writes 5000, waits, reads 5000
// (R13) decoder selects whole 5xxx region
// (R14) host interrupted once all channels done
// (R15) read drives result and clears done
`default_nettype none
module acv_conv
    import acv_pkg::*;
#(
    parameter int NCH = 1,
    parameter bit SELF_CLOCK = 1'b1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ext_cclk,
    input wire logic [NCH*ACV_DATA_W-1:0] positive_analog_input,
    input wire logic [NCH*ACV_DATA_W-1:0] negative_analog_input,
    acv_if.device bus
);
    logic wr_q;
    logic start_pulse;
    logic rd_act;
    logic cclk_q;
    logic cclk_prev_q;
    logic cclk_rise;
    logic [$clog2(ACV_CCLK_DIV)-1:0] div_q;

    // start happens on the rising edge of the write strobe with chip select low
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_q <= 1'b1;
        end else begin
            wr_q <= bus.wr_n | bus.cs_n;
        end
    end
    assign start_pulse = !wr_q && (bus.wr_n | bus.cs_n); // (R10)
    assign rd_act = !bus.cs_n && !bus.rd_n;

    // own divider or host-supplied clock picks the approximation pace
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_q <= '0;
            cclk_q <= 1'b0;
            cclk_prev_q <= 1'b0;
        end else begin
            div_q <= (div_q == ($clog2(ACV_CCLK_DIV))'(ACV_CCLK_DIV - 1)) ? '0 : div_q + 1'b1;
            cclk_q <= SELF_CLOCK ? div_q[$high(div_q)] : ext_cclk; // (R8)
            cclk_prev_q <= cclk_q;
        end
    end
    assign cclk_rise = cclk_q && !cclk_prev_q;

    generate
        for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
            acv_state_e st_q;
            logic [3:0] step_q;
            logic [ACV_DATA_W-1:0] sar_q;
            logic [ACV_DATA_W-1:0] res_q;
            logic [ACV_DATA_W-1:0] target;
            logic done_n_q;
            logic oe_q;
            logic [ACV_DATA_W:0] diff;
            logic [ACV_DATA_W-1:0] trial;

            // differential code; sampled code already holds the half-step offset
            assign diff = {1'b0, positive_analog_input[ch*ACV_DATA_W +: ACV_DATA_W]}
                - {1'b0, negative_analog_input[ch*ACV_DATA_W +: ACV_DATA_W]};
            assign target = diff[ACV_DATA_W] ? ACV_CODE_ZERO : diff[ACV_DATA_W-1:0]; // (R6) (R7)
            assign trial = sar_q | (8'h80 >> step_q);

            // approximation sequencer; a new start always resets it
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    st_q <= ACV_IDLE;
                    step_q <= 4'h0;
                    sar_q <= ACV_CODE_ZERO;
                end else if (start_pulse) begin
                    st_q <= ACV_CONV; // (R1)
                    step_q <= 4'h0;
                    sar_q <= ACV_CODE_ZERO;
                end else begin
                    unique case (st_q)
                        ACV_IDLE, ACV_DONE: st_q <= ACV_IDLE;
                        ACV_CONV: begin
                            if (cclk_rise) begin
                                if (step_q == 4'(ACV_CONV_STEPS - 1)) begin
                                    st_q <= ACV_DONE;
                                end else begin
                                    if (step_q < 4'(ACV_DATA_W) && trial <= target) begin
                                        sar_q <= trial;
                                    end
                                    step_q <= step_q + 4'h1;
                                end
                            end
                        end
                        default: st_q <= ACV_IDLE;
                    endcase
                end
            end

            // result latch loads only on completion, so an abort leaves it intact
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    res_q <= ACV_CODE_ZERO;
                end else if (st_q == ACV_DONE && !start_pulse) begin
                    res_q <= sar_q; // (R2)
                end
            end

            // done flag: completion sets it, read or new start clears it
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    done_n_q <= 1'b1;
                end else if (st_q == ACV_DONE && !start_pulse) begin
                    done_n_q <= 1'b0;
                end else if (rd_act || start_pulse || !wr_q) begin
                    done_n_q <= 1'b1; // (R3) (R15)
                end
            end

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    oe_q <= 1'b0;
                end else begin
                    oe_q <= rd_act; // (R15)
                end
            end

            assign bus.conversion_done_n[ch] = done_n_q;
            assign bus.dev_data[ch*ACV_DATA_W +: ACV_DATA_W] = res_q;
            assign bus.dev_data_oe[ch] = oe_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ===== verilog/acv_host.sv
// acv_host: host side sequencer driving start, wait and read of all channels
// assumes the converter end shares the clock; data bus resolved by the bench
`default_nettype none
module acv_host
    import acv_pkg::*;
#(
    parameter int NCH = 1,
    parameter int WAIT_STATES = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic free_run,
    input wire logic run,
    output logic busy,
    output logic [ACV_ADDR_W-1:0] store_addr,
    output logic [ACV_DATA_W-1:0] store_data,
    output logic store_valid,
    acv_if.host bus
);
    acv_host_e st_q;
    logic [7:0] cnt_q;
    logic [$clog2(NCH+1)-1:0] ch_q;
    logic cs_n_q, wr_n_q, rd_n_q;
    logic [ACV_ADDR_W-1:0] addr_q, ptr_q;
    logic [ACV_DATA_W-1:0] sd_q;
    logic sv_q, busy_q;
    logic any_pending;

    // combine done lines: interrupt only when every channel is done
    assign any_pending = |bus.conversion_done_n; // (R14)

    // bus sequencing; waits stretch each strobe for a slow converter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= ACV_H_INIT;
            cnt_q <= 8'h00;
            ch_q <= '0;
            cs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            addr_q <= ACV_CONV_ADDR;
            ptr_q <= ACV_STORE_FIRST;
            sd_q <= ACV_CODE_ZERO;
            sv_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            sv_q <= 1'b0;
            unique case (st_q)
                ACV_H_INIT: begin
                    // one low pulse on the joined node after power-up
                    cs_n_q <= 1'b0;
                    wr_n_q <= 1'b0; // (R5)
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(ACV_INIT_PULSE - 1)) begin
                        wr_n_q <= 1'b1;
                        cnt_q <= 8'h00;
                        st_q <= free_run ? ACV_H_FREE : ACV_H_START;
                        cs_n_q <= free_run ? 1'b0 : 1'b1;
                    end
                end
                ACV_H_FREE: begin
                    cs_n_q <= 1'b0; // (R4)
                    wr_n_q <= bus.conversion_done_n[0]; // (R4)
                    rd_n_q <= 1'b1;
                    if (!free_run) begin
                        cs_n_q <= 1'b1;
                        wr_n_q <= 1'b1;
                        st_q <= ACV_H_START;
                    end
                end
                ACV_H_START: begin
                    busy_q <= 1'b0;
                    if (free_run) begin
                        // a read has left done high, so free-run needs a fresh low pulse
                        cnt_q <= 8'h00;
                        st_q <= ACV_H_INIT; // (R5)
                    end else if (run) begin
                        busy_q <= 1'b1;
                        addr_q <= ACV_CONV_ADDR; // (R12)
                        cs_n_q <= addr_q[ACV_ADDR_W-1 -: 4] != ACV_DEC_NIBBLE; // (R13)
                        wr_n_q <= 1'b0;
                        cnt_q <= 8'h00;
                        st_q <= ACV_H_STROBE;
                    end
                end
                ACV_H_STROBE: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(WAIT_STATES)) begin // (R9)
                        wr_n_q <= 1'b1;
                        cs_n_q <= 1'b1;
                        st_q <= ACV_H_WAIT;
                    end
                end
                ACV_H_WAIT: begin
                    if (!any_pending) begin // (R14)
                        ch_q <= '0;
                        cnt_q <= 8'h00;
                        addr_q <= ACV_CONV_ADDR;
                        cs_n_q <= 1'b0;
                        rd_n_q <= 1'b0;
                        st_q <= ACV_H_READ;
                    end
                end
                ACV_H_READ: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(WAIT_STATES + 1)) begin // (R9)
                        sd_q <= bus.dev_data[ch_q*ACV_DATA_W +: ACV_DATA_W];
                        sv_q <= 1'b1;
                        rd_n_q <= 1'b1;
                        cs_n_q <= 1'b1;
                        st_q <= ACV_H_RELEASE;
                    end
                end
                ACV_H_RELEASE: begin
                    // advance pointer, wrapping at the last slot
                    ptr_q <= (ptr_q == ACV_STORE_LAST) ? ACV_STORE_FIRST : ptr_q + 16'h0001; // (R11)
                    cnt_q <= 8'h00;
                    if (ch_q == ($clog2(NCH+1))'(NCH - 1)) begin
                        st_q <= ACV_H_START;
                    end else begin
                        ch_q <= ch_q + 1'b1;
                        addr_q <= addr_q + 16'h0001;
                        cs_n_q <= 1'b0;
                        rd_n_q <= 1'b0;
                        st_q <= ACV_H_READ;
                    end
                end
                default: st_q <= ACV_H_START;
            endcase
        end
    end

    assign bus.cs_n = cs_n_q;
    assign bus.wr_n = wr_n_q;
    assign bus.rd_n = rd_n_q;
    assign bus.addr = addr_q;
    assign busy = busy_q;
    assign store_addr = ptr_q;
    assign store_data = sd_q;
    assign store_valid = sv_q;
endmodule
`default_nettype wire

// ===== testbench/acv_sva.sv
// acv_sva: timing checks on the bus joining converter and host
// assumes the bench top wires the interface signals in by name
`default_nettype none
module acv_sva
    import acv_pkg::*;
#(
    parameter int NCH = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [ACV_ADDR_W-1:0] addr,
    input wire logic [NCH-1:0] conversion_done_n,
    input wire logic [NCH*ACV_DATA_W-1:0] dev_data,
    input wire logic [NCH-1:0] dev_data_oe
);
    logic wlow_q;
    logic [7:0] age_q;
    logic start;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // a start is the release of a low write pair
    assign start = wlow_q && (cs_n || wr_n);
    // age since the last start saturates, so a long idle never wraps
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wlow_q <= 1'b0;
            age_q <= 8'hff;
        end else begin
            wlow_q <= !cs_n && !wr_n;
            if (start) begin
                age_q <= 8'h00;
            end else if (age_q != 8'hff) begin
                age_q <= age_q + 8'h01;
            end
        end
    end
    chk_done_quiet: assert property (start |-> ##2 (&conversion_done_n)[*8])
        else $error("done low right after a start");
    chk_done_bound: assert property (start |->
        ##[1:80] (!conversion_done_n[0] || (!cs_n && !wr_n)))
        else $error("conversion never finished");
    chk_done_early: assert property ($fell(conversion_done_n[0]) |-> age_q >= 8'd30)
        else $error("done too soon after start");
    chk_latch_hold: assert property ($changed(dev_data) |-> age_q >= 8'd30)
        else $error("result changed without completion");
    chk_oe_cause: assert property (dev_data_oe[0] |-> $past(!cs_n && !rd_n))
        else $error("data driven without read");
    chk_oe_follow: assert property ((!cs_n && !rd_n) |=> dev_data_oe[0])
        else $error("read not answered");
    chk_read_clear: assert property (($fell(rd_n) && !cs_n) |->
        ##[1:2] conversion_done_n[0])
        else $error("read left done low");
    chk_chan_sync: assert property ($fell(conversion_done_n[0]) |->
        conversion_done_n == '0)
        else $error("channels finished apart");
    chk_dec_match: assert property ((!cs_n && !wr_n) |->
        addr[15:12] == ACV_DEC_NIBBLE)
        else $error("write outside decoded region");
endmodule
`default_nettype wire

// ===== testbench/test_adc_conversion_host_control.sv
// test_adc_conversion_host_control: host and converter pair, plus a bench-driven converter
// assumes the package, interface, both design ends and acv_sva compile first
`default_nettype none
module test_adc_conversion_host_control
    import acv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rstn, ext_cclk, free_run, run, busy, sv, pd;
    logic [15:0] ain_p, ain_n, sa;
    logic [7:0] bp, bn, sd, old;
    int bad_count, checked, cycles, k, n;
    acv_if #(.NCH(2)) bus_a (.clock(clock));
    acv_if bus_b (.clock(clock));
    acv_conv #(.NCH(2)) u_acv_conv (.clock(clock), .rstn(rstn), .ext_cclk(ext_cclk),
        .positive_analog_input(ain_p), .negative_analog_input(ain_n), .bus(bus_a.device));
    acv_host #(.NCH(2)) u_acv_host (.clock(clock), .rstn(rstn), .free_run(free_run),
        .run(run), .busy(busy), .store_addr(sa), .store_data(sd), .store_valid(sv),
        .bus(bus_a.host));
    // second converter uses the bench clock, so both clock sources run
    acv_conv #(.SELF_CLOCK(1'b0)) u_acv_conv_b (.clock(clock), .rstn(rstn),
        .ext_cclk(ext_cclk), .positive_analog_input(bp), .negative_analog_input(bn),
        .bus(bus_b.device));
    acv_sva #(.NCH(2)) u_acv_sva (.clock(clock), .rstn(rstn), .cs_n(bus_a.cs_n),
        .wr_n(bus_a.wr_n), .rd_n(bus_a.rd_n), .addr(bus_a.addr),
        .conversion_done_n(bus_a.conversion_done_n), .dev_data(bus_a.dev_data),
        .dev_data_oe(bus_a.dev_data_oe));
    function automatic logic [7:0] code(input logic [7:0] p, input logic [7:0] m);
        // below the zero reference the code pins at zero
        return (p >= m) ? p - m : ACV_CODE_ZERO;
    endfunction
    task automatic cyc();
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // bench acts as host of the second converter
    task automatic bwrite();
        bus_b.cs_n = 1'b0;
        bus_b.wr_n = 1'b0;
        cyc();
        bus_b.cs_n = 1'b1;
        bus_b.wr_n = 1'b1;
        cyc();
    endtask
    // bounded wait; a count near 36 shows a full conversion from scratch
    task automatic bwait();
        n = 0;
        while (bus_b.conversion_done_n !== 1'b0 && n < 200) begin
            cyc();
            n++;
        end
        chk(16'(n >= 28 && n <= 60), 16'h0001);
    endtask
    task automatic bread(input logic [7:0] exp);
        bus_b.cs_n = 1'b0;
        bus_b.rd_n = 1'b0;
        cyc();
        chk(16'(bus_b.dev_data_oe), 16'h0001);
        chk(16'(bus_b.dev_data), 16'(exp));
        bus_b.cs_n = 1'b1;
        bus_b.rd_n = 1'b1;
        repeat (2) cyc();
        chk(16'(bus_b.conversion_done_n), 16'h0001);
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        ext_cclk = 1'b0;
        forever #16 ext_cclk = ~ext_cclk;
    end
    // each store must carry its channel's code and advance the pointer
    always @(posedge clock) begin
        cycles++;
        if (sv === 1'b1 && !free_run) begin
            chk(sa, ACV_STORE_FIRST + 16'(k % 16));
            chk(16'(sd), 16'(code(ain_p[8*(k%2)+:8], ain_n[8*(k%2)+:8])));
            k++;
        end
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        rstn = 1'b0;
        free_run = 1'b0;
        run = 1'b0;
        ain_p = 16'h0000;
        ain_n = 16'h0000;
        bp = 8'h00;
        bn = 8'h00;
        bus_b.cs_n = 1'b1;
        bus_b.wr_n = 1'b1;
        bus_b.rd_n = 1'b1;
        bus_b.addr = ACV_CONV_ADDR;
        n = $urandom(27265);
        repeat (16) @(posedge clock);
        #1 rstn = 1'b1;
        // the power-up pulse alone must launch a conversion
        n = 0;
        while (bus_a.conversion_done_n[0] !== 1'b0 && n < 100) begin
            cyc();
            n++;
        end
        chk(16'(n < 100), 16'h0001);
        // host passes; the first holds the top and bottom codes
        for (int i = 0; i < 9; i++) begin
            ain_n = (i == 0) ? 16'h3300 : 16'($urandom) & 16'h7f7f;
            ain_p = (i == 0) ? 16'h20ff : ain_n | 16'($urandom);
            run = 1'b1;
            cyc();
            run = 1'b0;
            repeat (2) cyc();
            chk(16'(busy), 16'h0001);
            n = 0;
            while (busy !== 1'b0 && n < 300) begin
                cyc();
                n++;
            end
        end
        chk(16'(k), 16'd18);
        // complete once, then abort a conversion with a restart
        bn = 8'($urandom) & 8'h3f;
        bp = bn | 8'($urandom);
        old = code(bp, bn);
        bwrite();
        bwait();
        bread(old);
        bp = bn | 8'($urandom);
        bwrite();
        repeat (15) begin
            cyc();
            chk(16'(bus_b.conversion_done_n), 16'h0001);
        end
        bp = ~bn;
        bwrite();
        chk(16'(bus_b.dev_data), 16'(old));
        bwait();
        bread(code(bp, bn));
        // free running: every completion must retrigger the next
        free_run = 1'b1;
        n = 0;
        repeat (300) begin
            pd = bus_a.conversion_done_n[0];
            cyc();
            if (pd === 1'b1 && bus_a.conversion_done_n[0] === 1'b0) begin
                n++;
            end
        end
        chk(16'(n >= 3), 16'h0001);
        final_report();
    end
endmodule
`default_nettype wire
